// ### icr_pkg.sv
package icr_pkg;

    // source numbering used for request, mask and in-service vectors
    localparam int NUM_SRC = 7;
    localparam int SRC_TIMER = 0;
    localparam int SRC_DMA0 = 1;
    localparam int SRC_DMA1 = 2;
    localparam int SRC_PIN0 = 3;
    localparam int SRC_PIN1 = 4;
    localparam int SRC_PIN2 = 5;
    localparam int SRC_PIN3 = 6;
    localparam int NUM_PINS = 4;
    localparam int NUM_CASC = 2;

    // register offsets within the peripheral control block
    localparam logic [7:0] OFS_PIN3_CTRL = 8'h3E;
    localparam logic [7:0] OFS_PIN2_CTRL = 8'h3C;
    localparam logic [7:0] OFS_PIN1_CTRL = 8'h3A;
    localparam logic [7:0] OFS_PIN0_CTRL = 8'h38;
    localparam logic [7:0] OFS_DMA1_CTRL = 8'h36;
    localparam logic [7:0] OFS_DMA0_CTRL = 8'h34;
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h32;
    localparam logic [7:0] OFS_REQUEST = 8'h2E;
    localparam logic [7:0] OFS_IN_SERVICE = 8'h2C;
    localparam logic [7:0] OFS_MASK = 8'h28;

    // control register field positions
    localparam int CTL_PRIO_LSB = 0;
    localparam int CTL_PRIO_W = 3;
    localparam int CTL_MASK_BIT = 3;
    localparam int CTL_LVL_BIT = 4;
    localparam int CTL_CAS_BIT = 5;
    localparam int CTL_SPECIAL_NESTING_ENABLE_BIT = 6;

    // reset values
    localparam logic [2:0] RST_PRIO = 3'h7;
    localparam logic RST_MASK = 1'b1;
    localparam logic RST_LVL = 1'b0;
    localparam logic RST_CAS = 1'b0;
    localparam logic RST_SPECIAL_NESTING_ENABLE = 1'b0;
    localparam logic RST_REQ = 1'b0;

    // source index width for the presented request
    localparam int SRC_IDX_W = 3;

endpackage : icr_pkg

// ### icr_request_cell.sv
`timescale 1ns/1ps
`default_nettype none

module icr_request_cell
    import icr_pkg::*;
#(
    parameter bit IS_PIN = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic src_in,
    input wire logic level_mode,
    input wire logic ack,
    input wire logic sw_we,
    input wire logic sw_val,
    output logic pending
);

    logic req_r;
    logic req_nxt;
    logic prev_r;
    logic prev_nxt;
    logic set_ev;
    logic withdraw;

    ////////////////////////////////////////////////////////////////////////////
    // trigger detection and request latch
    always_comb begin
        prev_nxt = src_in;
        if (IS_PIN) begin
            // edge detect rearms only once the pin has been seen low
            set_ev = level_mode ? src_in : (src_in & ~prev_r); // see R3, R17, R18
            withdraw = ~src_in; // see R13
        end else begin
            set_ev = src_in;
            withdraw = 1'b0;
        end
        // set wins so an event during ack or a clear is never lost
        if (set_ev) begin
            req_nxt = 1'b1; // see R10
        end else if (ack || withdraw) begin
            req_nxt = 1'b0; // see R11, R13
        end else if (sw_we) begin
            req_nxt = sw_val;
        end else begin
            req_nxt = req_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            req_r <= RST_REQ; // see R14
            prev_r <= 1'b0;
        end else begin
            req_r <= req_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign pending = req_r;

endmodule : icr_request_cell

`default_nettype wire

// ### icr_irq_control_request_mask.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: each source has its own control register with priority field and mask bit
// R2: mask bit is one storage bit seen in control and common mask register
// R3: pin trigger select bit: 0 edge, 1 level
// R4: cascadable pins zero and one carry a cascade enable bit
// R5: cascadable pins zero and one carry a special nesting enable bit
// R6: mask bits reset to 1, source disabled until software clears it
// R7: priority fields reset to 111
// R8: trigger select, cascade and nesting enables reset to 0
// R9: software sets level mode on a pin with a cascaded slave
// R10: request bit sets on a source request regardless of its mask
// R11: request bit clears when its interrupt is acknowledged
// R12: external source holds its pin asserted until acknowledged
// R13: pin withdrawn before acknowledge clears its request, no service
// R14: one request bit per source, timers share one, all reset 0
// R15: set bit in common mask register disables that source
// R16: software writes zero to reserved bits
// R17: edge mode requests on rising pin; pin must fall to rearm
// R18: level mode keeps requesting while pin is high, even after ack
// R19: acknowledge also sets the source's in-service bit
// R20: present highest priority pending unmasked request, fixed order breaks ties
module icr_irq_control_request_mask
    import icr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [15:0] WDATA,
    output logic [15:0] RDATA,
    input wire logic [3:0] EXTERNAL_IRQ_PINS,
    input wire logic [1:0] DMA_CHANNEL_REQUESTS,
    input wire logic SHARED_TIMER_REQUEST,
    input wire logic ACK,
    input wire logic [6:0] IN_SERVICE_CLEAR,
    output logic IRQ_OUT,
    output logic [2:0] IRQ_SOURCE,
    output logic [6:0] IN_SERVICE,
    output logic [1:0] CASCADE_ENABLE
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    // control register state, one slot per source
    logic [2:0] prio_r [NUM_SRC];
    logic [2:0] prio_nxt [NUM_SRC];
    logic [NUM_SRC-1:0] mask_r;
    logic [NUM_SRC-1:0] mask_nxt;
    logic [NUM_PINS-1:0] lvl_r;
    logic [NUM_PINS-1:0] lvl_nxt;
    logic [NUM_CASC-1:0] cas_r;
    logic [NUM_CASC-1:0] cas_nxt;
    logic [NUM_CASC-1:0] special_nesting_enable_r;
    logic [NUM_CASC-1:0] special_nesting_enable_nxt;

    // in-service, read-back and presented request state
    logic [NUM_SRC-1:0] inserv_r;
    logic [NUM_SRC-1:0] inserv_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [2:0] src_r;
    logic [2:0] src_nxt;

    // combinational helpers
    logic [NUM_SRC-1:0] raw_src;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] ack_vec;
    logic [NUM_SRC-1:0] eligible;
    logic [NUM_SRC-1:0] src_lvl;
    logic req_we;
    logic hit_req;
    logic hit_mask;
    logic hit_inserv;
    logic [NUM_SRC-1:0] nest_ok;

    // address decode shared by writes and reads
    function automatic int ctrl_index(input logic [7:0] a);
        case (a)
            OFS_TIMER_CTRL: ctrl_index = SRC_TIMER;
            OFS_DMA0_CTRL: ctrl_index = SRC_DMA0;
            OFS_DMA1_CTRL: ctrl_index = SRC_DMA1;
            OFS_PIN0_CTRL: ctrl_index = SRC_PIN0;
            OFS_PIN1_CTRL: ctrl_index = SRC_PIN1;
            OFS_PIN2_CTRL: ctrl_index = SRC_PIN2;
            OFS_PIN3_CTRL: ctrl_index = SRC_PIN3;
            default: ctrl_index = -1;
        endcase
    endfunction : ctrl_index

    // true for any of the seven control register slots
    function automatic logic is_ctrl(input int ci);
        is_ctrl = (ci >= 0);
    endfunction : is_ctrl

    // only the pins have a trigger select bit
    function automatic logic has_trigger(input int ci);
        has_trigger = (ci >= SRC_PIN0);
    endfunction : has_trigger

    // only the two cascadable pins carry cascade and nesting bits
    function automatic logic has_cascade(input int ci);
        has_cascade = (ci == SRC_PIN0) || (ci == SRC_PIN1);
    endfunction : has_cascade

    ////////////////////////////////////////////////////////////////////////////
    // request latches, one per source; timers share a single input
    assign raw_src = {EXTERNAL_IRQ_PINS, DMA_CHANNEL_REQUESTS, SHARED_TIMER_REQUEST};
    assign src_lvl = {lvl_r, 3'h0};
    // fixed-offset registers, decoded once for the write and read paths
    assign hit_req = (ADDR == OFS_REQUEST);
    assign hit_mask = (ADDR == OFS_MASK);
    assign hit_inserv = (ADDR == OFS_IN_SERVICE);
    assign req_we = WR_EN && hit_req;
    // acknowledge goes to whichever source is currently presented;
    // an ack with nothing shown is dropped, it could only hit a stale source
    always_comb begin
        ack_vec = '0;
        if (ACK && irq_r) begin
            ack_vec[src_r] = 1'b1; // see R11
        end
    end

    // the three timers share one cell; which timer fired is kept outside
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_req
            icr_request_cell #(
                .IS_PIN(gi >= SRC_PIN0)
            ) u_cell (
                .clk(CLK),
                .rst(RST),
                .src_in(raw_src[gi]),
                .level_mode(src_lvl[gi]),
                .ack(ack_vec[gi]),
                .sw_we(req_we),
                .sw_val(WDATA[gi]),
                .pending(pending[gi]) // see R10, R14
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // control and mask registers
    always_comb begin
        int ci;
        ci = ctrl_index(ADDR);
        prio_nxt = prio_r;
        mask_nxt = mask_r;
        lvl_nxt = lvl_r;
        cas_nxt = cas_r;
        special_nesting_enable_nxt = special_nesting_enable_r;
        if (WR_EN && is_ctrl(ci)) begin
            prio_nxt[ci] = WDATA[CTL_PRIO_LSB +: CTL_PRIO_W]; // see R1
            // the mask bit has a single flop, so both views always agree
            mask_nxt[ci] = WDATA[CTL_MASK_BIT]; // see R2
            if (has_trigger(ci)) begin
                lvl_nxt[ci - SRC_PIN0] = WDATA[CTL_LVL_BIT]; // see R3
            end
            if (has_cascade(ci)) begin
                cas_nxt[ci - SRC_PIN0] = WDATA[CTL_CAS_BIT]; // see R4
                special_nesting_enable_nxt[ci - SRC_PIN0] = WDATA[CTL_SPECIAL_NESTING_ENABLE_BIT]; // see R5
            end
        end
        // one address per access, so the two views never collide in a cycle;
        // reserved upper bits of the mask word are simply not stored
        if (WR_EN && hit_mask) begin
            mask_nxt = WDATA[NUM_SRC-1:0]; // see R2, R15
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                prio_r[i] <= RST_PRIO; // see R7
            end
            // every source starts masked so nothing fires before setup
            mask_r <= {NUM_SRC{RST_MASK}}; // see R6
            lvl_r <= {NUM_PINS{RST_LVL}}; // see R8
            cas_r <= {NUM_CASC{RST_CAS}}; // see R8
            special_nesting_enable_r <= {NUM_CASC{RST_SPECIAL_NESTING_ENABLE}}; // see R8
        end else begin
            prio_r <= prio_nxt;
            mask_r <= mask_nxt;
            lvl_r <= lvl_nxt;
            cas_r <= cas_nxt;
            special_nesting_enable_r <= special_nesting_enable_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // in-service tracking; ack sets, outside end-of-interrupt logic clears
    // the clear pulse names sources by bit, one per in-service flag
    always_comb begin
        // set wins over a clear landing in the same cycle
        inserv_nxt = (inserv_r & ~IN_SERVICE_CLEAR) | ack_vec; // see R19
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            inserv_r <= '0;
        end else begin
            inserv_r <= inserv_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // a source in service is held back so its own handler is not re-entered;
    // special nesting on the cascadable pins lifts that, letting a cascaded
    // slave's more urgent request through while an earlier one is served
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_nest
            if (gi == SRC_PIN0 || gi == SRC_PIN1) begin : g_casc
                assign nest_ok[gi] = ~inserv_r[gi] | special_nesting_enable_r[gi - SRC_PIN0]; // see R5
            end else begin : g_plain
                assign nest_ok[gi] = ~inserv_r[gi];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // arbitration: lowest priority value wins, lower index breaks ties
    // so the timer beats the dma channels and those beat the pins
    always_comb begin
        logic [2:0] best;
        logic found;
        best = RST_PRIO;
        found = 1'b0;
        src_nxt = src_r;
        // masked sources stay out, as do those held back by in-service
        eligible = pending & ~mask_r & nest_ok; // see R15
        for (int i = 0; i < NUM_SRC; i++) begin
            if (eligible[i] && (!found || prio_r[i] < best)) begin
                best = prio_r[i];
                found = 1'b1;
                src_nxt = 3'(i); // see R20
            end
        end
        // the acked request is dropping this cycle, so withdraw the line now;
        // showing it one more cycle would invite a second ack of the same source
        irq_nxt = found && !(ACK && irq_r && src_nxt == src_r); // see R20
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_r <= 1'b0;
            src_r <= '0;
        end else begin
            irq_r <= irq_nxt;
            src_r <= src_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port; reserved and unmapped bits read zero
    // the word is held until the next read, so a slow core still sees it
    always_comb begin
        int ci;
        ci = ctrl_index(ADDR);
        rdata_nxt = rdata_r;
        if (RD_EN) begin
            rdata_nxt = '0;
            if (is_ctrl(ci)) begin
                rdata_nxt[CTL_PRIO_LSB +: CTL_PRIO_W] = prio_r[ci];
                rdata_nxt[CTL_MASK_BIT] = mask_r[ci]; // see R2
                if (has_trigger(ci)) begin
                    rdata_nxt[CTL_LVL_BIT] = lvl_r[ci - SRC_PIN0];
                end
                if (has_cascade(ci)) begin
                    rdata_nxt[CTL_CAS_BIT] = cas_r[ci - SRC_PIN0];
                    rdata_nxt[CTL_SPECIAL_NESTING_ENABLE_BIT] = special_nesting_enable_r[ci - SRC_PIN0];
                end
            end else if (hit_req) begin
                rdata_nxt[NUM_SRC-1:0] = pending;
            end else if (hit_mask) begin
                rdata_nxt[NUM_SRC-1:0] = mask_r;
            end else if (hit_inserv) begin
                rdata_nxt[NUM_SRC-1:0] = inserv_r;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    // cascade bits only go out to the pin muxing; nothing here acts on them
    assign RDATA = rdata_r;
    assign IRQ_OUT = irq_r;
    assign IRQ_SOURCE = src_r;
    assign IN_SERVICE = inserv_r;
    assign CASCADE_ENABLE = cas_r; // see R4

endmodule : icr_irq_control_request_mask

`default_nettype wire

// ### icr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module icr_checker
    import icr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic WR_EN,
    input wire logic [15:0] WDATA,
    input wire logic ACK,
    input wire logic IRQ_OUT,
    input wire logic [2:0] IRQ_SOURCE,
    input wire logic [6:0] IN_SERVICE,
    input wire logic [1:0] CASCADE_ENABLE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // an acknowledge only counts while a request is shown
    sequence s_acked;
        ACK && IRQ_OUT;
    endsequence
    quiet_reset_a: assert property (
        $fell(RST) |-> !IRQ_OUT && IN_SERVICE == 7'h00 && CASCADE_ENABLE == 2'h0)
        else $error("outputs busy after reset");
    isr_from_ack_a: assert property (
        s_acked |=> IN_SERVICE[$past(IRQ_SOURCE)])
        else $error("in-service not set by ack");
    isr_only_ack_a: assert property (
        !$past(ACK && IRQ_OUT) |-> (IN_SERVICE & ~$past(IN_SERVICE)) == 7'h00)
        else $error("in-service set without ack");
    ack_retires_a: assert property (
        s_acked |=> !(IRQ_OUT && IRQ_SOURCE == $past(IRQ_SOURCE)))
        else $error("acked request still shown");
    mask_all_a: assert property (
        WR_EN && ADDR == OFS_MASK && WDATA[6:0] == 7'h7F |-> ##2 !IRQ_OUT [*2])
        else $error("request shown while all masked");
    dma1_masked_a: assert property (
        WR_EN && ADDR == OFS_DMA1_CTRL && WDATA[CTL_MASK_BIT]
        |-> ##2 !(IRQ_OUT && IRQ_SOURCE == 3'h2))
        else $error("masked dma1 shown");
    casc_zero_a: assert property (
        WR_EN && ADDR == OFS_PIN0_CTRL |=> CASCADE_ENABLE[0] == $past(WDATA[CTL_CAS_BIT]))
        else $error("cascade bit zero wrong");
    casc_one_a: assert property (
        WR_EN && ADDR == OFS_PIN1_CTRL |=> CASCADE_ENABLE[1] == $past(WDATA[CTL_CAS_BIT]))
        else $error("cascade bit one wrong");
endmodule : icr_checker
`default_nettype wire

// ### icr_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module icr_src_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [6:0] fire,
    input wire logic [6:0] drop,
    input wire logic ack,
    input wire logic irq_out,
    input wire logic [2:0] irq_source,
    output logic [6:0] src
);
    logic [6:0] held_r;
    logic [6:0] held_nxt;
    // pins stay up until acked or dropped; internal sources only pulse
    always_comb begin
        held_nxt = held_r & ~drop;
        if (ack && irq_out) begin
            held_nxt[irq_source] = 1'b0;
        end
        held_nxt = (held_nxt | fire) & 7'h78;
    end
    always_ff @(posedge clk) begin
        held_r <= rst ? 7'h00 : held_nxt;
    end
    assign src = held_r | {4'h0, fire[2:0]};
endmodule : icr_src_model
`default_nettype wire

// ### icr_irq_control_request_mask_test.sv
`timescale 1ns/1ps
`default_nettype none
module icr_irq_control_request_mask_test;
    import icr_pkg::*;
    logic clk, rst, wr_en, rd_en, ack, irq_out;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic [6:0] isr_clr, in_service, fire, drop, src;
    logic [2:0] irq_source;
    logic [1:0] cascade_enable;
    logic [7:0] ctl_ofs [7] = '{OFS_TIMER_CTRL, OFS_DMA0_CTRL, OFS_DMA1_CTRL,
        OFS_PIN0_CTRL, OFS_PIN1_CTRL, OFS_PIN2_CTRL, OFS_PIN3_CTRL};
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    icr_irq_control_request_mask i_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WR_EN(wr_en),
        .RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata), .EXTERNAL_IRQ_PINS(src[6:3]),
        .DMA_CHANNEL_REQUESTS(src[2:1]), .SHARED_TIMER_REQUEST(src[0]), .ACK(ack),
        .IN_SERVICE_CLEAR(isr_clr), .IRQ_OUT(irq_out), .IRQ_SOURCE(irq_source),
        .IN_SERVICE(in_service), .CASCADE_ENABLE(cascade_enable));
    icr_src_model i_src (.clk(clk), .rst(rst), .fire(fire), .drop(drop), .ack(ack),
        .irq_out(irq_out), .irq_source(irq_source), .src(src));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd
    // source model latches pins; internal sources see one cycle
    task automatic pulse(input logic [6:0] b);
        @(posedge clk);
        fire <= b;
        @(posedge clk);
        fire <= 7'h00;
    endtask : pulse
    // settle arbitration, check the shown source, then take it
    task automatic ackx(input logic [2:0] s);
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        #1;
        while (irq_out !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        chk({13'h0, irq_source}, {13'h0, s});
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : ackx
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    // guard against a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        rst <= 1'b1;
        {wr_en, rd_en, ack} <= 3'h0;
        {addr, wdata, isr_clr, fire, drop} <= '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (ctl_ofs[i]) rd(ctl_ofs[i], 16'h000F);
        rd(OFS_MASK, 16'h007F);
        rd(OFS_REQUEST, 16'h0000);
        rd(8'h30, 16'h0000);
        $display("reset values done");
        wr(OFS_PIN0_CTRL, 16'h0072);
        rd(OFS_PIN0_CTRL, 16'h0072);
        chk({14'h0, cascade_enable}, 16'h0001);
        wr(OFS_TIMER_CTRL, 16'h0077);
        rd(OFS_TIMER_CTRL, 16'h0007);
        wr(OFS_PIN3_CTRL, 16'h0075);
        rd(OFS_PIN3_CTRL, 16'h0015);
        $display("fields done");
        wr(OFS_MASK, 16'h0000);
        rd(OFS_DMA0_CTRL, 16'h0007);
        wr(OFS_DMA1_CTRL, 16'h000D);
        rd(OFS_MASK, 16'h0004);
        pulse(7'h04);
        rd(OFS_REQUEST, 16'h0004);
        chk({15'h0, irq_out}, 16'h0000);
        $display("masking done");
        wr(OFS_PIN3_CTRL, 16'h0005);
        wr(OFS_DMA1_CTRL, 16'h0005);
        pulse(7'h41);
        ackx(3'h2);
        ackx(3'h6);
        ackx(3'h0);
        chk({9'h0, in_service}, 16'h0045);
        rd(OFS_IN_SERVICE, 16'h0045);
        rd(OFS_REQUEST, 16'h0000);
        @(posedge clk);
        isr_clr <= 7'h7F;
        @(posedge clk);
        isr_clr <= 7'h00;
        $display("priority done");
        wr(OFS_PIN1_CTRL, 16'h0000);
        pulse(7'h10);
        repeat (4) @(posedge clk);
        #1 chk({13'h0, irq_source}, 16'h0004);
        @(posedge clk);
        drop <= 7'h10;
        @(posedge clk);
        drop <= 7'h00;
        rd(OFS_REQUEST, 16'h0000);
        chk({9'h0, in_service}, 16'h0000);
        $display("withdraw done");
        wr(OFS_PIN0_CTRL, 16'h0010);
        @(posedge clk);
        fire <= 7'h08;
        ackx(3'h3);
        rd(OFS_REQUEST, 16'h0008);
        chk({9'h0, in_service}, 16'h0008);
        wr(OFS_PIN0_CTRL, 16'h0050);
        repeat (2) @(posedge clk);
        #1 chk({12'h0, irq_out, irq_source}, 16'h000B);
        @(posedge clk);
        fire <= 7'h00;
        drop <= 7'h08;
        @(posedge clk);
        drop <= 7'h00;
        wr(OFS_MASK, 16'h007F);
        repeat (3) @(posedge clk);
        #1 chk({15'h0, irq_out}, 16'h0000);
        $display("level done");
        give_verdict();
    end
endmodule : icr_irq_control_request_mask_test
bind icr_irq_control_request_mask icr_checker i_chk (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WR_EN(WR_EN), .WDATA(WDATA), .ACK(ACK), .IRQ_OUT(IRQ_OUT), .IRQ_SOURCE(IRQ_SOURCE),
    .IN_SERVICE(IN_SERVICE), .CASCADE_ENABLE(CASCADE_ENABLE));
`default_nettype wire
